// >>> logic/spst_pkg.sv
/*
  Constants for the socket present-state register bank: APB offsets,
  field positions, reset values, event bits and timing counts.
  Assumes a 100 MHz pclk and 32-bit APB data with byte addresses.
*/
package spst_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PRESENT   = 8'h00;
  localparam logic [7:0] OFS_FORCE     = 8'h04;
  localparam logic [7:0] OFS_CONTROL   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  // Present-state and force field positions
  localparam int BIT_RETEST    = 14;
  localparam int BIT_EXTRA_CAP = 12;
  localparam int BIT_LOW_CAP   = 11;
  localparam int BIT_HIGH_CAP  = 10;
  localparam int BIT_ILLEGAL   = 9;
  localparam int BIT_LOSS      = 8;
  localparam int BIT_NOT_CARD  = 7;
  localparam int BIT_CINT      = 6;
  localparam int BIT_CB        = 5;
  localparam int BIT_PC16      = 4;
  localparam int BIT_PWR_DONE  = 3;
  localparam int BIT_CD2       = 2;
  localparam int BIT_CD1       = 1;
  localparam int BIT_WAKE      = 0;

  // Socket supply capability bits, fixed at 4'h3
  localparam logic [3:0] SOCKET_CAPS = 4'h3;

  // Supply select codes in the control register
  localparam logic [1:0] VCC_OFF  = 2'h0;
  localparam logic [1:0] VCC_HIGH = 2'h1;
  localparam logic [1:0] VCC_LOW  = 2'h2;

  // Interrupt event bits
  localparam int EV_DETECT  = 0;
  localparam int EV_LOSS    = 1;
  localparam int EV_ILLEGAL = 2;
  localparam int EV_POWER   = 3;
  localparam int EV_WAKE    = 4;
  localparam int EV_W       = 5;

  // Reset values
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0]      VCC_RST      = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SENSE_SETTLE_NS = 1000;
  localparam int POWER_RAMP_NS   = 20000;
  localparam logic [11:0] SENSE_SETTLE_CYC =
    12'((SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] POWER_RAMP_CYC =
    12'((POWER_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {DET_IDLE, DET_DRIVE, DET_SENSE} spst_det_t;
  typedef enum logic [1:0] {PWR_OFF, PWR_RAMP, PWR_ON} spst_pwr_t;

endpackage

// >>> logic/spst_top.sv
/*
  Socket present-state register bank with force path, card detection,
  supply request checking and a masked interrupt, on an APB slave.
  Assumes socket pins are asynchronous and the supply controller
  reports supply_good; xfer_pending comes from the pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module spst_top (
  // APB slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                pclk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Socket pins
  input  wire logic                card_detect_first_n,
  input  wire logic                card_detect_second_n,
  input  wire logic [1:0]          voltage_sense_pins_in,
  output var  logic [1:0]          voltage_sense_pins_out,
  output var  logic [1:0]          voltage_sense_pins_oe,
  input  wire logic                card_interrupt_pin_n,
  input  wire logic                card_status_wake_pin,
  // Bridge side
  input  wire logic                xfer_pending,
  input  wire logic                supply_good,
  output var  logic                socket_power_enable,
  output var  logic                cardbus_mode,
  output var  logic                pc16_mode,
  output var  logic                irq
);
  import spst_pkg::*;

  localparam int SW = 7;

  logic [SW-1:0]   pin_raw;
  logic [SW-1:0]   pin_s1;
  logic [SW-1:0]   pin_s2;
  logic            cd1;
  logic            cd2;
  logic [1:0]      vs;
  logic            cint_n;
  logic            wake;
  logic            pgood;
  logic            cd1_prev;
  logic            cd2_prev;
  logic            wake_prev;
  logic            low_cap;
  logic            high_cap;
  logic            illegal_req;
  logic            removal_loss;
  logic            not_card;
  logic            cb_type;
  logic            pc16_type;
  logic            pwr_done;
  logic            cd1_lat;
  logic            cd2_lat;
  logic            forced_inhibit;
  logic [1:0]      vcc_sel;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] next_irq_status;
  logic [EV_W-1:0] ev;
  logic [11:0]     det_cnt;
  logic [11:0]     pwr_cnt;
  spst_det_t       det_state;
  spst_pwr_t       pwr_state;
  logic            acc_go;
  logic            wr_go;
  logic            wr_present;
  logic            wr_force;
  logic            wr_control;
  logic            mapped;
  logic [31:0]     rd_val;
  logic            cd_change;
  logic            card_in;
  logic            removal;
  logic            det_done;
  logic            force_caps;
  logic            retest_go;
  logic            req_legal;
  logic            req_allowed;
  logic            pwr_fail;
  logic            ramp_done;

  // Pin synchronisers, two flops per pin
  assign pin_raw = {supply_good, card_status_wake_pin, card_interrupt_pin_n,
                    voltage_sense_pins_in, card_detect_second_n, card_detect_first_n};

  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_s1[i] <= 1'b1;
        pin_s2[i] <= 1'b1;
      end else if (pclk_en) begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
      end
    end
  end

  assign cd1    = pin_s2[0];
  assign cd2    = pin_s2[1];
  assign vs     = pin_s2[3:2];
  assign cint_n = pin_s2[4];
  assign wake   = pin_s2[5];
  assign pgood  = pin_s2[6];

  // Pin history for change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cd1_prev  <= 1'b1;
      cd2_prev  <= 1'b1;
      wake_prev <= 1'b1; // Synchroniser resets high; avoids a false wake edge
    end else if (pclk_en) begin
      cd1_prev  <= cd1;
      cd2_prev  <= cd2;
      wake_prev <= wake;
    end
  end

  assign cd_change = (cd1 != cd1_prev) || (cd2 != cd2_prev);
  assign card_in   = !cd1 && !cd2;
  assign removal   = !cd1_prev && !cd2_prev && !card_in;

  // APB decode; one wait state, writes act on the completing edge
  assign acc_go     = psel && penable && pready;
  assign wr_go      = acc_go && pwrite;
  assign wr_present = wr_go && (paddr == OFS_PRESENT);
  assign wr_force   = wr_go && (paddr == OFS_FORCE);
  assign wr_control = wr_go && (paddr == OFS_CONTROL);
  assign mapped     = (paddr == OFS_PRESENT) || (paddr == OFS_FORCE) ||
                      (paddr == OFS_CONTROL) || (paddr == OFS_IRQ_STAT) ||
                      (paddr == OFS_IRQ_MASK);
  assign retest_go  = wr_force && pwdata[BIT_RETEST];
  assign force_caps = wr_force && (pwdata[BIT_LOW_CAP] || pwdata[BIT_HIGH_CAP]);

  // Read mux; bits 12, 6 and 0 are not stored
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFS_PRESENT: begin
        rd_val[31:28]         = SOCKET_CAPS;
        rd_val[BIT_EXTRA_CAP] = 1'b0;
        rd_val[BIT_LOW_CAP]   = low_cap;
        rd_val[BIT_HIGH_CAP]  = high_cap;
        rd_val[BIT_ILLEGAL]   = illegal_req;
        rd_val[BIT_LOSS]      = removal_loss;
        rd_val[BIT_NOT_CARD]  = not_card;
        rd_val[BIT_CINT]      = !cint_n;
        rd_val[BIT_CB]        = cb_type;
        rd_val[BIT_PC16]      = pc16_type;
        rd_val[BIT_PWR_DONE]  = pwr_done;
        rd_val[BIT_CD2]       = cd2_lat;
        rd_val[BIT_CD1]       = cd1_lat;
        rd_val[BIT_WAKE]      = wake;
      end
      OFS_CONTROL:  rd_val[1:0]      = vcc_sel;
      OFS_IRQ_STAT: rd_val[EV_W-1:0] = irq_status;
      OFS_IRQ_MASK: rd_val[EV_W-1:0] = irq_mask;
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // APB answer: pready one cycle after access starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (pclk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // Detection sequence: drive sense pins low, latch detect, then sense
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_state             <= DET_IDLE;
      det_cnt               <= 12'h000;
      cd1_lat               <= 1'b1;
      cd2_lat               <= 1'b1;
      voltage_sense_pins_oe <= 2'h0;
    end else if (pclk_en) begin
      unique case (det_state)
        DET_IDLE: begin
          if (retest_go || cd_change) begin
            det_state             <= DET_DRIVE;
            det_cnt               <= SENSE_SETTLE_CYC;
            voltage_sense_pins_oe <= 2'h3;
          end
        end
        DET_DRIVE: begin
          if (det_cnt == 12'h001) begin
            cd1_lat               <= cd1;
            cd2_lat               <= cd2;
            voltage_sense_pins_oe <= 2'h0;
            det_cnt               <= SENSE_SETTLE_CYC;
            det_state             <= DET_SENSE;
          end else begin
            det_cnt <= det_cnt - 12'h001;
          end
        end
        DET_SENSE: begin
          if (det_cnt == 12'h001) begin
            det_state <= DET_IDLE;
          end else begin
            det_cnt <= det_cnt - 12'h001;
          end
        end
      endcase
    end
  end

  assign det_done = (det_state == DET_SENSE) && (det_cnt == 12'h001);

  // Sense pins are only ever pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_sense_pins_out <= 2'h0;
    end else if (pclk_en) begin
      voltage_sense_pins_out <= 2'h0;
    end
  end

  // Capability flags from detection or force; forcing locks out power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cap        <= 1'b0;
      high_cap       <= 1'b0;
      forced_inhibit <= 1'b0;
    end else if (pclk_en) begin
      if (det_done) begin
        low_cap        <= !cd1_lat && !cd2_lat && !vs[1];
        high_cap       <= !cd1_lat && !cd2_lat && vs[0];
        forced_inhibit <= 1'b0;
      end
      if (wr_force && pwdata[BIT_LOW_CAP]) begin
        low_cap <= 1'b1;
      end
      if (wr_force && pwdata[BIT_HIGH_CAP]) begin
        high_cap <= 1'b1;
      end
      if (force_caps) begin
        forced_inhibit <= 1'b1;
      end
    end
  end

  // Card type flags, held until another type is found
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      not_card  <= 1'b0;
      cb_type   <= 1'b0;
      pc16_type <= 1'b0;
    end else if (pclk_en) begin
      if (det_done && !cd1_lat && !cd2_lat) begin
        cb_type   <= (vs == 2'h1);
        pc16_type <= vs[1];
        if (vs != 2'h0) begin
          not_card <= 1'b0;
        end else begin
          not_card <= 1'b1;
        end
      end
      // Force path ignored while a card sits in the socket
      if (wr_force && !card_in) begin
        if (pwdata[BIT_NOT_CARD]) begin
          not_card <= 1'b1;
        end
        if (pwdata[BIT_CB]) begin
          cb_type <= 1'b1;
        end
        if (pwdata[BIT_PC16]) begin
          pc16_type <= 1'b1;
        end
      end
    end
  end

  // Socket interface mode follows the type flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cardbus_mode <= 1'b0;
      pc16_mode    <= 1'b0;
    end else if (pclk_en) begin
      cardbus_mode <= cb_type;
      pc16_mode    <= pc16_type && !cb_type;
    end
  end

  // Supply request check; 16-bit cards skip the voltage match but not the force or unknown-card lockouts
  assign req_legal   = pc16_type ||
                       ((pwdata[1:0] == VCC_HIGH) && high_cap) ||
                       ((pwdata[1:0] == VCC_LOW) && low_cap);
  assign req_allowed = req_legal && !forced_inhibit && !not_card;
  assign pwr_fail    = wr_control && (pwdata[1:0] != VCC_OFF) && !req_allowed;
  assign ramp_done   = (pwr_state == PWR_RAMP) && (pwr_cnt == 12'h001);

  // Error flags; illegal_req has no clear, and a removal_loss set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_req  <= 1'b0;
      removal_loss <= 1'b0;
    end else if (pclk_en) begin
      if (wr_control && (pwdata[1:0] != VCC_OFF) && !req_legal) begin
        illegal_req <= 1'b1;
      end else if (wr_force && pwdata[BIT_ILLEGAL]) begin
        illegal_req <= 1'b1;
      end
      if ((removal && (xfer_pending || socket_power_enable)) ||
          (wr_force && pwdata[BIT_LOSS])) begin
        removal_loss <= 1'b1;
      end else if (wr_present && pwdata[BIT_LOSS]) begin
        removal_loss <= 1'b0;
      end
    end
  end

  // Power sequencer; removal or an unknown card drops the supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state           <= PWR_OFF;
      pwr_cnt             <= 12'h000;
      vcc_sel             <= VCC_RST;
      pwr_done            <= 1'b0;
      socket_power_enable <= 1'b0;
    end else if (pclk_en) begin
      if (removal || not_card) begin
        pwr_state           <= PWR_OFF;
        socket_power_enable <= 1'b0;
        pwr_done            <= 1'b0;
      end else if (wr_control) begin
        vcc_sel <= pwdata[1:0];
        if (pwdata[1:0] == VCC_OFF || pwr_fail) begin
          pwr_state           <= PWR_OFF;
          socket_power_enable <= 1'b0;
          pwr_done            <= 1'b0;
        end else begin
          pwr_state           <= PWR_RAMP;
          pwr_cnt             <= POWER_RAMP_CYC;
          socket_power_enable <= 1'b1;
        end
      end else if (pwr_state == PWR_RAMP) begin
        if (ramp_done) begin
          pwr_done            <= pgood;
          socket_power_enable <= pgood;
          pwr_state           <= pgood ? PWR_ON : PWR_OFF;
        end else begin
          pwr_cnt <= pwr_cnt - 12'h001;
        end
      end
    end
  end

  // Events feeding the sticky status
  always_comb begin
    ev             = '0;
    ev[EV_DETECT]  = det_done;
    ev[EV_LOSS]    = removal && (xfer_pending || socket_power_enable);
    ev[EV_ILLEGAL] = wr_control && (pwdata[1:0] != VCC_OFF) && !req_legal;
    ev[EV_POWER]   = ramp_done || wr_control;
    ev[EV_WAKE]    = wake && !wake_prev;
    next_irq_status = irq_status | ev;
    if (wr_go && (paddr == OFS_IRQ_STAT)) begin
      next_irq_status = (irq_status & ~pwdata[EV_W-1:0]) | ev;
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask   <= IRQ_MASK_RST;
      irq        <= 1'b0;
    end else if (pclk_en) begin
      irq_status <= next_irq_status;
      if (wr_go && (paddr == OFS_IRQ_MASK)) begin
        irq_mask <= pwdata[EV_W-1:0];
      end
      irq <= |(next_irq_status & irq_mask); // Registered from the next status, so it changes with irq_status
    end
  end

endmodule
`default_nettype wire

// >>> test/spst_card_model.sv
/*
  Inserted card as seen from the socket: detect, sense and pin levels.
  Assumes the bench chooses presence, sense strapping and pin states.
*/
`timescale 1ns/100ps
`default_nettype none
module spst_card_model (
  // Bench controls
  input  wire logic       present,
  input  wire logic [1:0] code,
  input  wire logic       cint,
  input  wire logic       wake,
  // Socket pins
  input  wire logic [1:0] vs_out,
  input  wire logic [1:0] vs_oe,
  output logic            cd1_n,
  output logic            cd2_n,
  output logic [1:0]      vs_in,
  output logic            cint_n,
  output logic            wake_pin
);
  // Empty socket: detect and sense lines rest on their pull-ups
  assign cd1_n    = !present;
  assign cd2_n    = !present;
  // Bridge drive wins over the card straps while it holds the lines
  assign vs_in[0] = vs_oe[0] ? vs_out[0] : (!present || code[0]);
  assign vs_in[1] = vs_oe[1] ? vs_out[1] : (!present || code[1]);
  // Interrupt is low true; wake rests low with no card
  assign cint_n   = !(present && cint);
  assign wake_pin = present && wake;
endmodule
`default_nettype wire

// >>> test/spst_chk_chk.sv
/*
  Assertions on the present-state bank, bound to spst_top.
  Sees only the top ports; assumes pclk_en stays high.
*/
`timescale 1ns/100ps
`default_nettype none
module spst_chk (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Socket pins
  input wire logic        card_detect_first_n,
  input wire logic        card_detect_second_n,
  input wire logic [1:0]  voltage_sense_pins_in,
  input wire logic [1:0]  voltage_sense_pins_out,
  input wire logic [1:0]  voltage_sense_pins_oe,
  input wire logic        card_interrupt_pin_n,
  input wire logic        card_status_wake_pin,
  // Bridge side
  input wire logic        xfer_pending,
  input wire logic        supply_good,
  input wire logic        socket_power_enable,
  input wire logic        cardbus_mode,
  input wire logic        pc16_mode,
  input wire logic        irq
);
  import spst_pkg::*;
  logic done, rd_pres, ctl_wr, lock;
  // Completed transfers as the slave answers them
  assign done    = psel && penable && pready;
  assign rd_pres = done && !pwrite && paddr == OFS_PRESENT;
  assign ctl_wr  = done && pwrite && paddr == OFS_CONTROL;
  // Lockout shadow, dropped at the retest write only, so a detection started by a card change leaves it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'h0;
    end else if (done && pwrite && paddr == OFS_FORCE) begin
      if (pwdata[BIT_RETEST]) begin
        lock <= 1'h0;
      end else if (pwdata[BIT_LOW_CAP] || pwdata[BIT_HIGH_CAP]) begin
        lock <= 1'h1;
      end
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_extra_zero; rd_pres |-> !prdata[BIT_EXTRA_CAP]; endproperty
  a_extra_zero: assert property (p_extra_zero) else $error("extra cap set");
  property p_cint_live;
    $stable(card_interrupt_pin_n)[*5] ##0 rd_pres |-> prdata[BIT_CINT] == !card_interrupt_pin_n;
  endproperty
  a_cint_live: assert property (p_cint_live) else $error("cint bit wrong");
  property p_wake_live;
    $stable(card_status_wake_pin)[*5] ##0 rd_pres |-> prdata[BIT_WAKE] == card_status_wake_pin;
  endproperty
  a_wake_live: assert property (p_wake_live) else $error("wake bit wrong");
  property p_lock; lock && ctl_wr |-> ##2 (!socket_power_enable)[*8]; endproperty
  a_lock: assert property (p_lock) else $error("power while forced");
  property p_nocard_off; rd_pres && prdata[BIT_NOT_CARD] |-> ##1 !socket_power_enable; endproperty
  a_nocard_off: assert property (p_nocard_off) else $error("unknown card powered");
  property p_power_off; ctl_wr && pwdata[1:0] == VCC_OFF |-> ##2 !socket_power_enable; endproperty
  a_power_off: assert property (p_power_off) else $error("power stays on");
  property p_sense_drive;
    |voltage_sense_pins_oe |-> voltage_sense_pins_oe == 2'h3 && voltage_sense_pins_out == 2'h0;
  endproperty
  a_sense_drive: assert property (p_sense_drive) else $error("sense drive bad");
  property p_force_ro; done && !pwrite && paddr == OFS_FORCE |-> prdata == 32'h0; endproperty
  a_force_ro: assert property (p_force_ro) else $error("force reads back");
  // Main scenarios reached
  c_detect: cover property ($fell(voltage_sense_pins_oe[0]));
  c_power: cover property ($rose(socket_power_enable));
  c_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

// >>> test/spst_tb_top.sv
/*
  Bench for spst_top: APB master, card model, queued read checks.
  Assumes the card model and the checker from this folder.
*/
`timescale 1ns/100ps
`default_nettype none
module spst_tb_top;
  import spst_pkg::*;
  // Clock, reset, APB
  logic        pclk = 1'h0, presetn = 1'h0, pclk_en = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  // Socket, bridge side and card controls
  logic        cd1_n, cd2_n, cint_n, wake_pin, pwr, cb_m, pc_m, irq;
  logic        xfer = 1'h0, good = 1'h1, present = 1'h0, cint = 1'h0, wake = 1'h0;
  logic [1:0]  vs_in, vs_out, vs_oe, code = 2'h0;
  // Expected notes and counters
  logic [31:0] q_m[$];
  logic [32:0] q_e[$];
  int          bad_count = 0, checked = 0, seed, r;

  spst_top i_spst_top (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_detect_first_n(cd1_n),
    .card_detect_second_n(cd2_n), .voltage_sense_pins_in(vs_in),
    .voltage_sense_pins_out(vs_out), .voltage_sense_pins_oe(vs_oe),
    .card_interrupt_pin_n(cint_n), .card_status_wake_pin(wake_pin), .xfer_pending(xfer),
    .supply_good(good), .socket_power_enable(pwr), .cardbus_mode(cb_m), .pc16_mode(pc_m),
    .irq(irq));
  spst_card_model i_spst_card_model (.present(present), .code(code), .cint(cint),
    .wake(wake), .vs_out(vs_out), .vs_oe(vs_oe), .cd1_n(cd1_n), .cd2_n(cd2_n),
    .vs_in(vs_in), .cint_n(cint_n), .wake_pin(wake_pin));

  always #5 pclk = !pclk;

  task automatic check(input logic [32:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer; its expected answer is noted before the request goes out
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, m, e,
                     input logic err);
    int n;
    q_m.push_back(m);
    q_e.push_back({err, e & m});
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      bad_count++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'h1, a, d, 32'h0, 32'h0, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    acc(1'h0, a, 32'h0, m, e, 1'h0);
  endtask

  // Oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1) begin
      check({pslverr, prdata & q_m[0]}, q_e[0]);
      void'(q_m.pop_front());
      void'(q_e.pop_front());
    end
  end

  initial begin
    seed = 98578;
    tick(8);
    presetn <= 1'h1;
    // Empty socket after reset and map edges
    rd(OFS_PRESENT, 32'hF000_3000, 32'h3000_0000);
    rd(OFS_IRQ_MASK, 32'h0000_001F, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0000_001F, 32'h0);
    rd(OFS_FORCE, 32'hFFFF_FFFF, 32'h0);
    acc(1'h0, 8'h40, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'h1);
    // 16-bit card: voltage checking off, so a mismatched request powers up
    code    <= 2'h3;
    present <= 1'h1;
    tick(260);
    rd(OFS_PRESENT, 32'h0000_1EB6, 32'h0000_0410);
    check(33'(pc_m), 33'h1);
    wr(OFS_CONTROL, {30'h0, VCC_LOW});
    tick(2100);
    rd(OFS_PRESENT, 32'h0000_0208, 32'h0000_0008);
    check(33'(pwr), 33'h1);
    wr(OFS_CONTROL, 32'h0);
    tick(5);
    rd(OFS_PRESENT, 32'h0000_0008, 32'h0);
    // Removal with a transfer pending, then write-back clear
    xfer    <= 1'h1;
    present <= 1'h0;
    tick(260);
    xfer    <= 1'h0;
    rd(OFS_PRESENT, 32'h0000_0D36, 32'h0000_0116);
    wr(OFS_PRESENT, 32'hFFFF_FFFF);
    rd(OFS_PRESENT, 32'h0000_0D36, 32'h0000_0016);
    // Unknown card: no power, mismatched request flagged
    code    <= 2'h0;
    present <= 1'h1;
    tick(260);
    rd(OFS_PRESENT, 32'h0000_0CB6, 32'h0000_0880);
    wr(OFS_CONTROL, {30'h0, VCC_HIGH});
    tick(10);
    rd(OFS_PRESENT, 32'h0000_0208, 32'h0000_0200);
    check(33'(pwr), 33'h0);
    wr(OFS_CONTROL, 32'h0);
    // Swap in a CardBus card; the unknown flag gives way
    present <= 1'h0;
    tick(260);
    code    <= 2'h1;
    present <= 1'h1;
    tick(260);
    rd(OFS_PRESENT, 32'h0000_0CB6, 32'h0000_0C20);
    check(33'(cb_m), 33'h1);
    // Detect-done event: masked, unmasked, cleared
    rd(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    check(33'(irq), 33'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    tick(3);
    check(33'(irq), 33'h1);
    wr(OFS_IRQ_STAT, 32'h0000_001F);
    tick(3);
    check(33'(irq), 33'h0);
    // Forced capabilities lock power until a retest; type forces ignored
    wr(OFS_FORCE, 32'h0000_0CB0);
    rd(OFS_PRESENT, 32'h0000_0CB0, 32'h0000_0C20);
    wr(OFS_CONTROL, {30'h0, VCC_HIGH});
    tick(2100);
    check(33'(pwr), 33'h0);
    wr(OFS_FORCE, 32'h0000_4000);
    tick(260);
    wr(OFS_CONTROL, {30'h0, VCC_HIGH});
    tick(2100);
    check(33'(pwr), 33'h1);
    // Live pins under random levels
    repeat (6) begin
      r = $random(seed);
      cint <= r[0];
      wake <= r[1];
      tick(6);
      rd(OFS_PRESENT, 32'h0000_0041, {25'h0, r[0], 5'h0, r[1]});
    end
    // Enable low freezes the pin path; detection starts once it returns
    pclk_en <= 1'h0;
    present <= 1'h0;
    tick(20);
    check(33'(vs_oe), 33'h0);
    pclk_en <= 1'h1;
    tick(8);
    check(33'(vs_oe), 33'h3);
    end_of_test();
  end
endmodule

bind spst_top spst_chk i_spst_chk (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .card_detect_first_n(card_detect_first_n), .card_detect_second_n(card_detect_second_n),
  .voltage_sense_pins_in(voltage_sense_pins_in),
  .voltage_sense_pins_out(voltage_sense_pins_out),
  .voltage_sense_pins_oe(voltage_sense_pins_oe), .card_interrupt_pin_n(card_interrupt_pin_n),
  .card_status_wake_pin(card_status_wake_pin), .xfer_pending(xfer_pending),
  .supply_good(supply_good), .socket_power_enable(socket_power_enable),
  .cardbus_mode(cardbus_mode), .pc16_mode(pc16_mode), .irq(irq));
`default_nettype wire
